// ==== drs_pkg.sv ====
/*
 Package for the drive remote sequencer: command and state word layout,
 reset values, setpoint source codes and timing counts.
 Assumes a 100 MHz single clock.
*/
package drs_pkg;
   // ----------------------------------------
   // Word layout
   // ----------------------------------------
   localparam int WORD_W = 16;
   localparam logic [15:0] CMD_RESET = 16'h0000;
   localparam int CMD_ENABLE  = 0;
   localparam int CMD_START   = 1;
   localparam int CMD_INCH    = 2;
   localparam int CMD_INCHSEL = 3;
   localparam int CMD_ACK     = 8;
   localparam int CMD_LINK_OK = 9;
   localparam logic [15:0] CMD_RSVD_MASK = 16'hFCF0;
   localparam int ST_COAST   = 0;
   localparam int ST_PROG    = 1;
   localparam int ST_DISABLE = 2;
   localparam int ST_RUN     = 3;
   localparam int ST_INCH    = 4;
   localparam int ST_ALARM   = 6;
   localparam int ST_RUNNING = 8;
   localparam int ST_ENABLED = 9;
   localparam int ST_ZERO    = 10;
   localparam int ST_HEALTH  = 11;
   localparam int ST_READY   = 12;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int TICK_US = 1000;
   localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
   localparam int LINK_DELAY_MS_DEF = 1000;
   localparam int HOLD_OFF_MS_DEF = 1000;
   localparam int MS_W = 16;

   // ----------------------------------------
   // Enumerations
   // ----------------------------------------
   typedef enum logic [2:0]
   {
      DRS_SRC_NONE,
      DRS_SRC_PLAIN,
      DRS_SRC_INCH_A,
      DRS_SRC_INCH_B,
      DRS_SRC_CREEP,
      DRS_SRC_SLACK_A,
      DRS_SRC_SLACK_B
   } drs_src_t;

   typedef enum logic [1:0]
   {
      DRS_LINK_OK,
      DRS_LINK_WARN,
      DRS_LINK_ACTIVE
   } drs_link_t;
endpackage

// ==== drs_tick.sv ====
/*
 Millisecond enable divider.
 Assumes one free running clock.
*/
`timescale 1ns/100ps
module drs_tick
#(
   parameter int CYCLES = drs_pkg::TICK_CYCLES
)
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic nrst,
   // Enable out
   output logic      tick
);
   logic [31:0] cnt;
   logic [31:0] next_cnt;
   logic        next_tick;

   always_comb
   begin
      next_tick = 1'b0;
      next_cnt  = cnt + 32'h1;
      if (cnt == 32'(CYCLES - 1))
      begin
         next_cnt  = 32'h0;
         next_tick = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cnt  <= 32'h0;
         tick <= 1'b0;
      end
      else
      begin
         cnt  <= next_cnt;
         tick <= next_tick;
      end
   end
endmodule

// ==== drs_timer.sv ====
/*
 Millisecond up-timer: clear while run is low, count ticks, flag expiry.
 Assumes tick is a one-cycle enable.
*/
`timescale 1ns/100ps
module drs_timer
#(
   parameter int W = drs_pkg::MS_W
)
(
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         nrst,
   // Control
   input  wire logic         tick,
   input  wire logic         run,
   input  wire logic [W-1:0] length,
   // Status
   output logic              expired
);
   logic [W-1:0] cnt;
   logic [W-1:0] next_cnt;
   logic         next_expired;

   always_comb
   begin
      next_cnt     = cnt;
      next_expired = expired;
      if (!run)
      begin
         next_cnt     = '0;
         next_expired = 1'b0;
      end
      else if (tick && !expired)
      begin
         next_cnt = cnt + W'(1);
         if (cnt + W'(1) >= length)
            next_expired = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cnt     <= '0;
         expired <= 1'b0;
      end
      else
      begin
         cnt     <= next_cnt;
         expired <= next_expired;
      end
   end
endmodule

// ==== drs_sequencer.sv ====
/*
 Drive remote sequencer top: merges terminal and remote requests, picks
 the setpoint source, guards starts against alarms and stops, runs the
 link trip timer and the alarm latch, and builds the state word.
 Assumes all inputs synchronous to clk; the command word is written by
 a one-cycle strobe with data.
*/
// How it works
// - No run, inch, creep or slack start while an alarm is present.
// - Enable plus inch runs at inch speed A or B by select setting.
// - Contactor hold-off delay stops rapid inch toggling cycling contactor.
// - Select true, start and inch together gives creep speed.
// - Running, select false, inch adds slack offset A; release returns.
// - Running, select true adds slack offset B; false returns.
// - Command word 16 bits, resets zero, decodes bits 0-3, 8, 9.
// - Reserved bits read anything; controller writes zeros there.
// - State word reports stop, run, inch, alarm, health, ready bits.
// - State word reads 1B0B running, 044B or 0447 when tripped.
// - After acknowledge reads 0C47; alarm bit holds until restart.
// - Remote enable, start, inch, select bits gated by permit flag.
// - Alarms held latched until acknowledged; remote bit 8 acknowledges.
// - Controller writes 0300 to clear, then 0200 once healthy.
// - Bit 9 low starts link trip timer; trip on expiry unless inhibited.
// - Link trip state reports ok, warning or active.
// - After trip, need rising acknowledge and rising start to run.
// - No start while program-stop or coast-stop input is low.
`timescale 1ns/100ps
module drs_sequencer
#(
   parameter int MS_W = drs_pkg::MS_W,
   parameter int TICK = drs_pkg::TICK_CYCLES
)
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              nrst,
   // Command word port
   input  wire logic              cmd_wr,
   input  wire logic [15:0]       cmd_wdata,
   output logic      [15:0]       remote_command_word,
   output logic      [15:0]       sequence_state_word,
   // Terminals
   input  wire logic              term_enable,
   input  wire logic              term_start,
   input  wire logic              term_inch,
   input  wire logic              term_ack,
   input  wire logic              prog_stop_n,
   input  wire logic              coast_stop_n,
   // Settings
   input  wire logic              remote_sequencing_permit,
   input  wire logic              jog_slack_select,
   input  wire logic              link_trip_inhibit,
   input  wire logic [MS_W-1:0]   link_trip_delay,
   input  wire logic [MS_W-1:0]   contactor_hold_off,
   // Drive status in
   input  wire logic              alarm_in,
   input  wire logic              zero_speed,
   // Outputs
   output logic                   contactor,
   output logic                   drive_enable,
   output drs_pkg::drs_src_t      setpoint_src,
   output drs_pkg::drs_link_t     link_trip_state,
   output logic                   health_flag
);
   // ----------------------------------------
   // Request merge
   // ----------------------------------------
   logic r_en, r_start, r_inch, r_sel, r_ack, link_ok;
   logic req_en, req_start, req_inch, req_ack, stops_ok;
   logic tick, link_exp, hold_exp;

   assign r_en    = remote_sequencing_permit
                    & remote_command_word[drs_pkg::CMD_ENABLE];
   assign r_start = remote_sequencing_permit
                    & remote_command_word[drs_pkg::CMD_START];
   assign r_inch  = remote_sequencing_permit
                    & remote_command_word[drs_pkg::CMD_INCH];
   assign r_sel   = remote_sequencing_permit
                    & remote_command_word[drs_pkg::CMD_INCHSEL];
   // Ack bit works in remote mode regardless of permit
   assign r_ack   = remote_command_word[drs_pkg::CMD_ACK];
   assign link_ok = remote_command_word[drs_pkg::CMD_LINK_OK];
   assign req_en    = term_enable | r_en;
   assign req_start = term_start | r_start;
   assign req_inch  = term_inch | r_inch;
   assign req_ack   = term_ack | r_ack;
   assign stops_ok  = prog_stop_n & coast_stop_n;

   // ----------------------------------------
   // State registers
   // ----------------------------------------
   logic alarm_latch, next_alarm_latch;
   logic alarm_sticky, next_alarm_sticky;
   logic need_start, next_need_start;
   logic ack_d, start_d, next_ack_d, next_start_d;
   logic running, next_running;
   logic inch_act, next_inch_act;
   logic [15:0] next_cmd;
   logic [15:0] next_state;
   logic next_contactor;
   logic link_trip, hold_run;
   logic ack_rise, start_rise, permit_run;
   drs_pkg::drs_src_t next_src;

   drs_tick #(.CYCLES(TICK)) u_tick
   (
      .clk  (clk),
      .nrst (nrst),
      .tick (tick)
   );

   // Link timer runs while bit 9 is low, unless inhibited
   drs_timer #(.W(MS_W)) u_link
   (
      .clk     (clk),
      .nrst    (nrst),
      .tick    (tick),
      .run     (!link_ok && !link_trip_inhibit),
      .length  (link_trip_delay),
      .expired (link_exp)
   );

   // Hold-off keeps contactor in after inch released
   assign hold_run = contactor && !(running || inch_act);
   drs_timer #(.W(MS_W)) u_hold
   (
      .clk     (clk),
      .nrst    (nrst),
      .tick    (tick),
      .run     (hold_run),
      .length  (contactor_hold_off),
      .expired (hold_exp)
   );

   assign link_trip  = link_exp && !link_trip_inhibit;
   assign ack_rise   = req_ack && !ack_d;
   assign start_rise = req_start && !start_d;
   // Alarm blocks start; trip also needs fresh start edge
   assign permit_run = !alarm_latch && !alarm_sticky && stops_ok
                       && !(need_start && !start_rise);

   always_comb
   begin
      next_cmd = remote_command_word;
      if (cmd_wr)
         next_cmd = cmd_wdata;
      next_ack_d   = req_ack;
      next_start_d = req_start;
      // Set wins over acknowledge clear
      next_alarm_latch = alarm_latch;
      if (alarm_in || link_trip)
         next_alarm_latch = 1'b1;
      else if (ack_rise)
         next_alarm_latch = 1'b0;
      next_alarm_sticky = alarm_sticky;
      if (alarm_in || link_trip)
         next_alarm_sticky = 1'b1;
      else if (!alarm_latch && start_rise)
         next_alarm_sticky = 1'b0;
      next_need_start = need_start;
      if (link_trip)
         next_need_start = 1'b1;
      else if (!alarm_latch && start_rise)
         next_need_start = 1'b0;
      next_running = running;
      if (!req_en || !req_start || !stops_ok || alarm_latch)
         next_running = 1'b0;
      else if (!running && permit_run)
         next_running = 1'b1;
      next_inch_act = inch_act;
      if (!req_en || !req_inch || !stops_ok || alarm_latch)
         next_inch_act = 1'b0;
      else if (!inch_act && !alarm_latch && !alarm_sticky)
         next_inch_act = 1'b1;
      next_contactor = contactor;
      if (alarm_latch || !coast_stop_n)
         next_contactor = 1'b0;
      else if (running || inch_act)
         next_contactor = 1'b1;
      else if (hold_exp)
         next_contactor = 1'b0;
   end

   // ----------------------------------------
   // Setpoint source
   // ----------------------------------------
   always_comb
   begin
      next_src = drs_pkg::DRS_SRC_NONE;
      if (running && inch_act && jog_slack_select)
         next_src = drs_pkg::DRS_SRC_CREEP;
      else if (running && jog_slack_select)
         next_src = drs_pkg::DRS_SRC_SLACK_B;
      else if (running && inch_act)
         next_src = drs_pkg::DRS_SRC_SLACK_A;
      else if (running)
         next_src = drs_pkg::DRS_SRC_PLAIN;
      else if (inch_act)
         next_src = (jog_slack_select || r_sel)
                    ? drs_pkg::DRS_SRC_INCH_B
                    : drs_pkg::DRS_SRC_INCH_A;
   end

   // ----------------------------------------
   // State word
   // ----------------------------------------
   always_comb
   begin
      next_state = 16'h0000;
      next_state[drs_pkg::ST_COAST]   = coast_stop_n;
      next_state[drs_pkg::ST_PROG]    = prog_stop_n;
      next_state[drs_pkg::ST_DISABLE] = !req_en;
      next_state[drs_pkg::ST_RUN]     = req_start;
      next_state[drs_pkg::ST_INCH]    = req_inch;
      next_state[drs_pkg::ST_ALARM]   = alarm_sticky;
      next_state[drs_pkg::ST_RUNNING] = contactor;
      next_state[drs_pkg::ST_ENABLED] = running | inch_act;
      next_state[drs_pkg::ST_ZERO]    = zero_speed;
      next_state[drs_pkg::ST_HEALTH]  = !alarm_latch;
      next_state[drs_pkg::ST_READY]   = contactor && !alarm_latch;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         remote_command_word <= drs_pkg::CMD_RESET;
         sequence_state_word <= 16'h0000;
         alarm_latch  <= 1'b0;
         alarm_sticky <= 1'b0;
         need_start   <= 1'b0;
         ack_d        <= 1'b0;
         start_d      <= 1'b0;
         running      <= 1'b0;
         inch_act     <= 1'b0;
         contactor    <= 1'b0;
         setpoint_src <= drs_pkg::DRS_SRC_NONE;
      end
      else
      begin
         remote_command_word <= next_cmd;
         sequence_state_word <= next_state;
         alarm_latch  <= next_alarm_latch;
         alarm_sticky <= next_alarm_sticky;
         need_start   <= next_need_start;
         ack_d        <= next_ack_d;
         start_d      <= next_start_d;
         running      <= next_running;
         inch_act     <= next_inch_act;
         contactor    <= next_contactor;
         setpoint_src <= next_src;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign drive_enable = running | inch_act;
   assign health_flag  = !alarm_latch;
   always_comb
   begin
      if (link_exp && !link_trip_inhibit)
         link_trip_state = drs_pkg::DRS_LINK_ACTIVE;
      else if (!link_ok)
         link_trip_state = drs_pkg::DRS_LINK_WARN;
      else
         link_trip_state = drs_pkg::DRS_LINK_OK;
   end
endmodule

// ==== drs_host.sv ====
/*
 Host controller model: writes whole remote command words.
 Assumes the bench calls its tasks; strobes change at falling edges.
*/
`timescale 1ns/100ps
module drs_host
(
   // Clock and status
   input  wire logic        clk,
   input  wire logic        health_flag,
   // Command write port
   output logic             cmd_wr,
   output logic [15:0]      cmd_wdata
);
   initial
   begin
      cmd_wr = 1'b0;
      cmd_wdata = 16'hFFFF;
   end

   // Start and inch always travel in one word, so no mixed modes
   task automatic put(input logic [15:0] w);
      @(negedge clk);
      cmd_wr = 1'b1;
      cmd_wdata = w & ~drs_pkg::CMD_RSVD_MASK;
      @(negedge clk);
      cmd_wr = 1'b0;
      // Released data is not kept valid
      cmd_wdata = ~cmd_wdata;
   endtask

   task automatic link_fail();
      put(16'h0000);
   endtask

   task automatic clear_alarm();
      int n;
      put(16'h0300);
      n = 0;
      while (health_flag !== 1'b1 && n < 100)
      begin
         @(negedge clk);
         n++;
      end
      put(16'h0200);
   endtask
endmodule

// ==== drs_seq_properties.sv ====
/*
 Port checker for the sequencer top.
 Assumes binding to drs_sequencer, single clock domain.
*/
`timescale 1ns/100ps
module drs_seq_properties
(
   // Clock and reset
   input wire logic               clk,
   input wire logic               nrst,
   // Observed ports
   input wire logic               cmd_wr,
   input wire logic [15:0]        cmd_wdata,
   input wire logic [15:0]        remote_command_word,
   input wire logic [15:0]        sequence_state_word,
   input wire logic               prog_stop_n,
   input wire logic               coast_stop_n,
   input wire logic               link_trip_inhibit,
   input wire logic               zero_speed,
   input wire logic               drive_enable,
   input wire drs_pkg::drs_src_t  setpoint_src,
   input wire drs_pkg::drs_link_t link_trip_state,
   input wire logic               health_flag
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);

   // ----------------------------------------
   // Sequences
   // ----------------------------------------
   sequence s_alarm_held;
      !health_flag [*3];
   endsequence
   sequence s_coast_held;
      !coast_stop_n [*3];
   endsequence

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   chk_cmd_capture: assert property (cmd_wr |=>
      remote_command_word == $past(cmd_wdata)) else $error("word not taken");
   chk_cmd_hold: assert property (!cmd_wr |=>
      $stable(remote_command_word)) else $error("word changed unwritten");
   chk_alarm_block: assert property (s_alarm_held ##0
      $past(setpoint_src) == drs_pkg::DRS_SRC_NONE |->
      setpoint_src == drs_pkg::DRS_SRC_NONE) else $error("start in alarm");
   chk_coast_block: assert property (s_coast_held |->
      !drive_enable) else $error("enabled in coast stop");
   chk_link_warn: assert property ($fell(remote_command_word[9]) &&
      !link_trip_inhibit |-> link_trip_state == drs_pkg::DRS_LINK_WARN)
      else $error("no link warning");
   chk_link_ok: assert property (remote_command_word[9] |->
      link_trip_state != drs_pkg::DRS_LINK_WARN) else $error("false warning");
   chk_link_inhibit: assert property (link_trip_inhibit |->
      link_trip_state != drs_pkg::DRS_LINK_ACTIVE) else $error("inhibit lost");
   chk_state_inputs: assert property ($past(nrst) |->
      {sequence_state_word[10], sequence_state_word[1:0]} ==
      $past({zero_speed, prog_stop_n, coast_stop_n}))
      else $error("state word input bits wrong");
   chk_state_health: assert property ($past(nrst) |->
      sequence_state_word[drs_pkg::ST_HEALTH] == $past(health_flag))
      else $error("state word health bit wrong");
endmodule

bind drs_sequencer drs_seq_properties u_props
(
   .clk(clk), .nrst(nrst), .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata),
   .remote_command_word(remote_command_word),
   .sequence_state_word(sequence_state_word),
   .prog_stop_n(prog_stop_n), .coast_stop_n(coast_stop_n),
   .link_trip_inhibit(link_trip_inhibit), .zero_speed(zero_speed),
   .drive_enable(drive_enable), .setpoint_src(setpoint_src),
   .link_trip_state(link_trip_state), .health_flag(health_flag)
);

// ==== drs_sequencer_tb.sv ====
/*
 Self-checking bench for the sequencer with a host model.
 Assumes a shortened tick of 10 cycles per millisecond.
*/
`timescale 1ns/100ps
module drs_sequencer_tb;
   logic               clk;
   logic               nrst;
   logic               cmd_wr;
   logic [15:0]        cmd_wdata;
   logic [15:0]        cmd_word;
   logic [15:0]        state_word;
   logic               term_go;
   logic               prog_n;
   logic               coast_n;
   logic               permit;
   logic               jss;
   logic               inhibit;
   logic               zspd;
   logic               alm;
   logic               cont;
   logic               drv_en;
   logic               health;
   drs_pkg::drs_src_t  src;
   drs_pkg::drs_link_t link;
   int                 err_count;
   int                 cmp_count;

   drs_sequencer #(.TICK(10)) dut
   (
      .clk(clk), .nrst(nrst), .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata),
      .remote_command_word(cmd_word), .sequence_state_word(state_word),
      .term_enable(term_go), .term_start(term_go), .term_inch(1'b0),
      .term_ack(1'b0), .prog_stop_n(prog_n), .coast_stop_n(coast_n),
      .remote_sequencing_permit(permit), .jog_slack_select(jss),
      .link_trip_inhibit(inhibit), .link_trip_delay(16'h0003),
      .contactor_hold_off(16'h0003), .alarm_in(alm), .zero_speed(zspd),
      .contactor(cont), .drive_enable(drv_en), .setpoint_src(src),
      .link_trip_state(link), .health_flag(health)
   );
   drs_host host
   (
      .clk(clk), .health_flag(health), .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata)
   );

   task automatic chk_word(input string nm, input logic [15:0] e, g);
      cmp_count++;
      if (g !== e)
      begin
         err_count++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic chk_src(input string nm, input drs_pkg::drs_src_t e);
      cmp_count++;
      if (src !== e)
      begin
         err_count++;
         $display("BAD %s exp %0d got %0d", nm, e, src);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic go(input logic [15:0] w, input int n);
      host.put(w);
      idle(n);
   endtask
   task automatic print_verdict();
      if (err_count == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_run_slack();
      chk_word("cmd reset", 16'h0000, cmd_word);
      go(16'h0203, 40);
      chk_src("run", drs_pkg::DRS_SRC_PLAIN);
      chk_word("state run", 16'h1B0B, state_word);
      go(16'h0207, 4);
      chk_src("slack a", drs_pkg::DRS_SRC_SLACK_A);
      go(16'h0203, 4);
      chk_src("slack a off", drs_pkg::DRS_SRC_PLAIN);
      jss = 1'b1;
      idle(4);
      chk_src("slack b", drs_pkg::DRS_SRC_SLACK_B);
      jss = 1'b0;
      idle(4);
      chk_src("slack b off", drs_pkg::DRS_SRC_PLAIN);
      go(16'h0201, 40);
   endtask
   task automatic t_inch_creep();
      go(16'h0205, 40);
      chk_src("inch a", drs_pkg::DRS_SRC_INCH_A);
      go(16'h020D, 8);
      chk_src("inch b", drs_pkg::DRS_SRC_INCH_B);
      go(16'h0201, 40);
      jss = 1'b1;
      go(16'h0207, 40);
      chk_src("creep", drs_pkg::DRS_SRC_CREEP);
      go(16'h0201, 40);
      jss = 1'b0;
   endtask
   task automatic t_permit_stop();
      permit = 1'b0;
      go(16'h0203, 40);
      chk_src("no permit", drs_pkg::DRS_SRC_NONE);
      term_go = 1'b1;
      idle(40);
      chk_src("terminal run", drs_pkg::DRS_SRC_PLAIN);
      term_go = 1'b0;
      permit = 1'b1;
      go(16'h0201, 40);
      coast_n = 1'b0;
      go(16'h0203, 40);
      chk_word("coast en", 16'h0000, {15'h0000, drv_en});
      coast_n = 1'b1;
      prog_n = 1'b0;
      go(16'h0201, 2);
      go(16'h0203, 40);
      chk_src("prog stop", drs_pkg::DRS_SRC_NONE);
      prog_n = 1'b1;
      go(16'h0201, 40);
   endtask
   task automatic t_alarm_hold();
      go(16'h0205, 20);
      chk_word("inch cont", 16'h0001, {15'h0000, cont});
      go(16'h0201, 4);
      chk_word("hold cont", 16'h0001, {15'h0000, cont});
      go(16'h0205, 4);
      go(16'h0201, 50);
      chk_word("drop cont", 16'h0000, {15'h0000, cont});
      go(16'h0203, 40);
      alm = 1'b1;
      idle(4);
      chk_src("alarm stop", drs_pkg::DRS_SRC_NONE);
      alm = 1'b0;
      go(16'h0203, 20);
      chk_word("alarm latch", 16'h0000, {15'h0000, health});
      chk_src("alarm start", drs_pkg::DRS_SRC_NONE);
      host.clear_alarm();
      go(16'h0203, 40);
      chk_src("alarm restart", drs_pkg::DRS_SRC_PLAIN);
      go(16'h0201, 50);
   endtask
   task automatic t_link();
      go(16'h0203, 40);
      host.link_fail();
      idle(2);
      chk_word("link warn", 16'(drs_pkg::DRS_LINK_WARN), 16'(link));
      idle(60);
      chk_word("link act", 16'(drs_pkg::DRS_LINK_ACTIVE), 16'(link));
      chk_word("health", 16'h0000, {15'h0000, health});
      zspd = 1'b1;
      idle(3);
      chk_word("state trip", 16'h0447, state_word);
      go(16'h0203, 40);
      chk_src("trip start", drs_pkg::DRS_SRC_NONE);
      chk_word("state trip run", 16'h044B, state_word);
      host.clear_alarm();
      idle(3);
      chk_word("state ack", 16'h0C47, state_word);
      zspd = 1'b0;
      go(16'h0203, 40);
      chk_src("restart", drs_pkg::DRS_SRC_PLAIN);
      inhibit = 1'b1;
      host.link_fail();
      idle(60);
      chk_word("inhibit", 16'h0001, {15'h0000, health});
      go(16'h0200, 4);
      inhibit = 1'b0;
   endtask

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      {nrst, term_go, jss, inhibit, zspd} = 5'h00;
      alm = 1'b0;
      {prog_n, coast_n, permit} = 3'h7;
      err_count = 0;
      cmp_count = 0;
      repeat (5) @(negedge clk);
      nrst = 1'b1;
      t_run_slack();
      t_inch_creep();
      t_permit_stop();
      t_alarm_hold();
      t_link();
      print_verdict();
   end
   initial
   begin
      repeat (5000) @(posedge clk);
      err_count++;
      print_verdict();
   end
endmodule
